// File: pkg/link_event_pkg.sv
// Purpose: constants for the link event indication report block
// Assumes: register word of 16 bits, plain strobe bus
// Notes: codes and reasons as the link controller posts them
package link_event_pkg;
   localparam logic [3:0] code_init_done = 4'h2;
   localparam logic [3:0] code_watchdog = 4'h3;
   localparam logic [3:0] code_error = 4'h4;
   localparam logic [3:0] code_remote_busy = 4'h5;
   localparam logic [3:0] code_connect_ind = 4'h6;
   localparam logic [3:0] code_connect_conf = 4'h7;
   localparam logic [3:0] code_reset_ind = 4'h8;
   localparam logic [3:0] code_reset_conf = 4'h9;
   localparam logic [3:0] code_xid_ind = 4'ha;
   localparam logic [3:0] code_xid_conf = 4'hb;
   localparam logic [3:0] code_test_ind = 4'hc;
   localparam logic [3:0] code_test_conf = 4'hd;
   localparam logic [3:0] code_disc_ind = 4'he;
   localparam logic [3:0] code_disc_conf = 4'hf;
   localparam logic [1:0] reason_zero = 2'h0;
   localparam logic [1:0] reason_wd_tx = 2'h1;
   localparam logic [1:0] reason_wd_rx = 2'h2;
   localparam logic [1:0] reason_busy_set = 2'h0;
   localparam logic [1:0] reason_busy_clear = 2'h1;
   localparam logic [3:0] addr_status = 4'h0;
   localparam logic [3:0] addr_control = 4'h2;
   localparam int code_lsb = 0;
   localparam int reason_lsb = 4;
   localparam int pending_bit = 6;
   localparam int overrun_bit = 7;
   localparam int xid_enable_bit = 8;
   localparam int busy_enable_bit = 11;
   localparam int watchdog_enable_bit = 12;
   localparam logic [15:0] data_zero = 16'h0000;
endpackage

// File: hw/link_event_report.sv
// Purpose: posts link control indications to the host and holds the pending flag
// Assumes: event pulses come one-hot-ish from the link engine, synchronous to mclk
// Notes: one event is posted per cycle; lower code wins when several arrive together
// How it works
// - pending flag rises in the same cycle a new code is stored.
// - posting while pending sets overrun; clears with pending or reset; writes ignored.
// - only the device sets pending; host write-one or reset clears it.
// - four-bit code is stored together with setting pending.
// - reason field only meaningful for watchdog, disconnect, reset, error, busy codes.
// - disconnect and reset reasons carried from the engine as given.
// - init block read complete posts code 2.
// - watchdog expiry posts code 3 if enabled; reason 1 tx, 2 rx.
// - information transfer error posts code 4 with its reason.
// - remote busy change posts code 5 only when busy reporting enabled.
// - sabm received while disconnected posts code 6.
// - successful host connect posts code 7.
// - remote reset or retry timer expiry posts code 8.
// - successful host reset posts code 9.
// - xid command posts code 10 only when xid accept enabled.
// - xid response posts code 11 only when xid accept enabled.
// - test command posts code 12.
// - test response posts code 13.
// - disc received or refused request posts code 14.
// - completed host disconnect posts code 15.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
module link_event_report (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [3:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [15:0] bus_rdata,
   input wire logic ev_init_done,
   input wire logic ev_wd_tx,
   input wire logic ev_wd_rx,
   input wire logic ev_error,
   input wire logic [1:0] ev_error_reason,
   input wire logic ev_busy_change,
   input wire logic ev_busy_now,
   input wire logic ev_connect_ind,
   input wire logic ev_connect_conf,
   input wire logic ev_reset_ind,
   input wire logic [1:0] ev_reset_reason,
   input wire logic ev_reset_conf,
   input wire logic ev_xid_cmd,
   input wire logic ev_xid_rsp,
   input wire logic ev_test_cmd,
   input wire logic ev_test_rsp,
   input wire logic ev_disc_ind,
   input wire logic [1:0] ev_disc_ind_reason,
   input wire logic ev_disc_conf,
   input wire logic [1:0] ev_disc_conf_reason,
   output logic primitive_pending_flag,
   output logic indication_overrun_flag,
   output logic [3:0] indication_code,
   output logic [1:0] indication_reason,
   output logic busy_report_enable,
   output logic xid_accept_enable,
   output logic watchdog_enable
);

   typedef struct packed {
      logic pend;
      logic lost;
      logic [3:0] code;
      logic [1:0] reason;
      logic busy_en;
      logic xid_en;
      logic wd_en;
      logic [15:0] rdata;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic post;
   logic both_wd;
   logic [3:0] new_code;
   logic [1:0] new_reason;
   logic clr_pend;

   function automatic logic [15:0] status_word(input state_t s);
      logic [15:0] w;
      w = link_event_pkg::data_zero;
      w[link_event_pkg::code_lsb +: 4] = s.code;
      w[link_event_pkg::reason_lsb +: 2] = s.reason;
      w[link_event_pkg::pending_bit] = s.pend;
      w[link_event_pkg::overrun_bit] = s.lost;
      return w;
   endfunction

   // event selection, lowest code first
   always_comb
   begin
      post = 1'b1;
      both_wd = 1'b0;
      new_code = link_event_pkg::code_init_done;
      new_reason = link_event_pkg::reason_zero;
      if (ev_init_done)
      begin
         new_code = link_event_pkg::code_init_done;
      end
      else if (st_reg.wd_en && (ev_wd_tx || ev_wd_rx))
      begin
         new_code = link_event_pkg::code_watchdog;
         new_reason = ev_wd_tx ? link_event_pkg::reason_wd_tx : link_event_pkg::reason_wd_rx;
         both_wd = ev_wd_tx && ev_wd_rx;
      end
      else if (ev_error)
      begin
         new_code = link_event_pkg::code_error;
         new_reason = ev_error_reason;
      end
      else if (st_reg.busy_en && ev_busy_change)
      begin
         new_code = link_event_pkg::code_remote_busy;
         new_reason = ev_busy_now ? link_event_pkg::reason_busy_set
                                  : link_event_pkg::reason_busy_clear;
      end
      else if (ev_connect_ind)
      begin
         new_code = link_event_pkg::code_connect_ind;
      end
      else if (ev_connect_conf)
      begin
         new_code = link_event_pkg::code_connect_conf;
      end
      else if (ev_reset_ind)
      begin
         new_code = link_event_pkg::code_reset_ind;
         new_reason = ev_reset_reason;
      end
      else if (ev_reset_conf)
      begin
         new_code = link_event_pkg::code_reset_conf;
      end
      else if (st_reg.xid_en && ev_xid_cmd)
      begin
         new_code = link_event_pkg::code_xid_ind;
      end
      else if (st_reg.xid_en && ev_xid_rsp)
      begin
         new_code = link_event_pkg::code_xid_conf;
      end
      else if (ev_test_cmd)
      begin
         new_code = link_event_pkg::code_test_ind;
      end
      else if (ev_test_rsp)
      begin
         new_code = link_event_pkg::code_test_conf;
      end
      else if (ev_disc_ind)
      begin
         new_code = link_event_pkg::code_disc_ind;
         new_reason = ev_disc_ind_reason;
      end
      else if (ev_disc_conf)
      begin
         new_code = link_event_pkg::code_disc_conf;
         new_reason = ev_disc_conf_reason;
      end
      else
      begin
         post = 1'b0;
      end
   end

   always_comb
   begin
      st_next = st_reg;
      clr_pend = bus_wr && (bus_addr == link_event_pkg::addr_status)
                 && bus_wdata[link_event_pkg::pending_bit];
      if (bus_wr && (bus_addr == link_event_pkg::addr_control))
      begin
         st_next.xid_en = bus_wdata[link_event_pkg::xid_enable_bit];
         st_next.busy_en = bus_wdata[link_event_pkg::busy_enable_bit];
         st_next.wd_en = bus_wdata[link_event_pkg::watchdog_enable_bit];
      end
      if (clr_pend)
      begin
         st_next.pend = 1'b0;
         st_next.lost = 1'b0;
      end
      // a post in the clear cycle wins: the clear was meant for the old code
      if (post && (!st_reg.pend || clr_pend))
      begin
         st_next.code = new_code;
         st_next.reason = new_reason;
         st_next.pend = 1'b1;
         st_next.lost = both_wd;
      end
      else if (post)
      begin
         st_next.lost = 1'b1;
      end
      if (bus_rd && (bus_addr == link_event_pkg::addr_status))
      begin
         st_next.rdata = status_word(st_reg);
      end
      else if (bus_rd && (bus_addr == link_event_pkg::addr_control))
      begin
         st_next.rdata = link_event_pkg::data_zero;
         st_next.rdata[link_event_pkg::xid_enable_bit] = st_reg.xid_en;
         st_next.rdata[link_event_pkg::busy_enable_bit] = st_reg.busy_en;
         st_next.rdata[link_event_pkg::watchdog_enable_bit] = st_reg.wd_en;
      end
      else
      begin
         st_next.rdata = link_event_pkg::data_zero;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         st_reg <= '0;
      end
      else if (clk_en)
      begin
         st_reg <= st_next;
      end
   end

   assign bus_rdata = st_reg.rdata;
   assign primitive_pending_flag = st_reg.pend;
   assign indication_overrun_flag = st_reg.lost;
   assign indication_code = st_reg.code;
   assign indication_reason = st_reg.reason;
   assign busy_report_enable = st_reg.busy_en;
   assign xid_accept_enable = st_reg.xid_en;
   assign watchdog_enable = st_reg.wd_en;

   property p_post_sets_pending;
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && post && !st_reg.pend) |=> (st_reg.pend && st_reg.code == $past(new_code));
   endproperty
   a_post_sets_pending: assert property (p_post_sets_pending)
      else $error("post did not set pending");

   property p_overrun;
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && post && st_reg.pend && !clr_pend) |=> st_reg.lost && $stable(st_reg.code);
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("overrun not flagged");

   property p_pend_only_by_device;
      @(posedge mclk) disable iff (!rst_b)
      (!st_reg.pend && !(clk_en && post)) |=> !st_reg.pend;
   endproperty
   a_pend_only_by_device: assert property (p_pend_only_by_device)
      else $error("pending rose alone");

   property p_clear;
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && clr_pend && !post) |=> !st_reg.pend && !st_reg.lost;
   endproperty
   a_clear: assert property (p_clear)
      else $error("write one did not clear");

   property p_busy_gate;
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && !st_reg.pend && !st_reg.busy_en)
         |=> !(st_reg.pend && st_reg.code == link_event_pkg::code_remote_busy);
   endproperty
   a_busy_gate: assert property (p_busy_gate)
      else $error("busy posted while disabled");

   property p_xid_gate;
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && !st_reg.pend && !st_reg.xid_en) |=> !(st_reg.pend
         && (st_reg.code == link_event_pkg::code_xid_ind
         || st_reg.code == link_event_pkg::code_xid_conf));
   endproperty
   a_xid_gate: assert property (p_xid_gate)
      else $error("xid posted while disabled");

   property p_init_code;
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && ev_init_done && !st_reg.pend) |=> st_reg.code == link_event_pkg::code_init_done;
   endproperty
   a_init_code: assert property (p_init_code)
      else $error("init code wrong");

   property p_wd_both;
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && st_reg.wd_en && ev_wd_tx && ev_wd_rx && !ev_init_done && !st_reg.pend)
         |=> st_reg.lost && st_reg.code == link_event_pkg::code_watchdog;
   endproperty
   a_wd_both: assert property (p_wd_both)
      else $error("both watchdogs not marked");

   property p_disc_conf;
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && ev_disc_conf && !st_reg.pend && post
         && new_code == link_event_pkg::code_disc_conf)
         |=> st_reg.reason == $past(ev_disc_conf_reason);
   endproperty
   a_disc_conf: assert property (p_disc_conf)
      else $error("disconnect reason lost");

   property p_overrun_needs_pend;
      @(posedge mclk) disable iff (!rst_b)
      st_reg.lost |-> st_reg.pend;
   endproperty
   a_overrun_needs_pend: assert property (p_overrun_needs_pend)
      else $error("overrun flag set without pending");

   // no disable here: this one has to watch the reset itself
   property p_reset_clears;
      @(posedge mclk)
      !rst_b |=> !st_reg.pend && !st_reg.lost;
   endproperty
   a_reset_clears: assert property (p_reset_clears)
      else $error("reset left a flag set");

   property p_code_held;
      @(posedge mclk) disable iff (!rst_b)
      (st_reg.pend && !(clk_en && clr_pend))
         |=> $stable(st_reg.code) && $stable(st_reg.reason);
   endproperty
   a_code_held: assert property (p_code_held)
      else $error("code changed while pending");

   property p_reason_zero;
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && post && !st_reg.pend
         && new_code != link_event_pkg::code_watchdog
         && new_code != link_event_pkg::code_error
         && new_code != link_event_pkg::code_remote_busy
         && new_code != link_event_pkg::code_reset_ind
         && new_code != link_event_pkg::code_disc_ind
         && new_code != link_event_pkg::code_disc_conf)
         |=> st_reg.reason == link_event_pkg::reason_zero;
   endproperty
   a_reason_zero: assert property (p_reason_zero)
      else $error("reason not zero for a code without one");

   property p_wd_rx;
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && st_reg.wd_en && ev_wd_rx && !ev_wd_tx && !ev_init_done && !st_reg.pend)
         |=> st_reg.code == link_event_pkg::code_watchdog
         && st_reg.reason == link_event_pkg::reason_wd_rx;
   endproperty
   a_wd_rx: assert property (p_wd_rx)
      else $error("receive watchdog reason wrong");

   property p_busy_reason;
      @(posedge mclk) disable iff (!rst_b)
      (clk_en && post && new_code == link_event_pkg::code_remote_busy && !st_reg.pend)
         |=> st_reg.reason == ($past(ev_busy_now) ? link_event_pkg::reason_busy_set
                                                   : link_event_pkg::reason_busy_clear);
   endproperty
   a_busy_reason: assert property (p_busy_reason)
      else $error("busy reason wrong");
endmodule

// File: dv/host_model.sv
// Purpose: host side of the status and control port
// Assumes: one-cycle strobes, read data only in the cycle after the strobe
// Notes: write data is inverted once released so stale values never match
`timescale 1ns/1ps
module host_model (
   input wire logic mclk,
   output logic [3:0] bus_addr,
   output logic [15:0] bus_wdata,
   output logic bus_wr,
   output logic bus_rd,
   input wire logic [15:0] bus_rdata
);
   initial
   begin
      bus_addr = 4'h0;
      bus_wdata = 16'h0000;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge mclk);
      bus_wr <= 1'b0;
      bus_wdata <= ~d;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge mclk);
      bus_rd <= 1'b0;
      #1 d = bus_rdata;
   endtask
   // clear only after the code was read, so no indication is missed
   task automatic take(output logic [15:0] d);
      rd(link_event_pkg::addr_status, d);
      wr(link_event_pkg::addr_status, 16'h0040);
   endtask
endmodule

// File: dv/link_event_indication_report_tb.sv
// Purpose: self-checking bench of the indication report block
// Assumes: events are one-cycle pulses, status at 0x0, control at 0x2
// Notes: every code is posted once, then overrun, gating and clearing
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
   $display("BAD %0t got %h want %h", $time, g, e); end end
module link_event_indication_report_tb;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic [13:0] ev = '0;
   logic wd_rx = 1'b0;
   logic busy_now = 1'b1;
   logic [1:0] rsn = 2'h0;
   logic [3:0] bus_addr;
   logic [15:0] bus_wdata;
   logic [15:0] bus_rdata;
   logic bus_wr;
   logic bus_rd;
   logic pend;
   logic ovr;
   logic ben;
   logic xen;
   logic wen;
   logic [3:0] code;
   logic [1:0] rsn_o;
   logic [15:0] rd_v;
   logic [3:0] exp_code;
   logic [1:0] exp_rsn;
   int failures = 0;
   int total_checks = 0;
   always #4 mclk = ~mclk;
   host_model host (.mclk(mclk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
   link_event_report dut (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .ev_init_done(ev[0]), .ev_wd_tx(ev[1]), .ev_wd_rx(wd_rx),
      .ev_error(ev[2]), .ev_error_reason(rsn), .ev_busy_change(ev[3]),
      .ev_busy_now(busy_now), .ev_connect_ind(ev[4]), .ev_connect_conf(ev[5]),
      .ev_reset_ind(ev[6]), .ev_reset_reason(rsn), .ev_reset_conf(ev[7]),
      .ev_xid_cmd(ev[8]), .ev_xid_rsp(ev[9]), .ev_test_cmd(ev[10]),
      .ev_test_rsp(ev[11]), .ev_disc_ind(ev[12]), .ev_disc_ind_reason(rsn),
      .ev_disc_conf(ev[13]), .ev_disc_conf_reason(rsn),
      .primitive_pending_flag(pend), .indication_overrun_flag(ovr),
      .indication_code(code), .indication_reason(rsn_o), .busy_report_enable(ben),
      .xid_accept_enable(xen), .watchdog_enable(wen));
   task automatic print_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic pulse(input logic [13:0] m, input logic rx, input logic [1:0] r,
      input logic b);
      @(posedge mclk);
      ev <= m;
      wd_rx <= rx;
      rsn <= r;
      busy_now <= b;
      @(posedge mclk);
      ev <= '0;
      wd_rx <= 1'b0;
      #1;
   endtask
   task automatic ctl(input logic [15:0] v);
      host.wr(link_event_pkg::addr_control, v);
      host.rd(link_event_pkg::addr_control, rd_v);
      `CHK(rd_v, v)
      `CHK({wen, ben, xen}, {v[12], v[11], v[8]})
   endtask
   initial
   begin
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      `CHK({pend, ovr, code, rsn_o}, 8'h00)
      host.rd(4'h4, rd_v);
      `CHK(rd_v, 16'h0000)
      ctl(16'h1900);
      $display("test reset and control done");
      for (int i = 0; i < 14; i++)
      begin
         exp_code = 4'(i + 2);
         case (exp_code)
            4'h3: exp_rsn = 2'h1;
            4'h8: exp_rsn = 2'h2;
            4'h4, 4'he, 4'hf: exp_rsn = 2'h3;
            default: exp_rsn = 2'h0;
         endcase
         pulse(14'(1 << i), 1'b0, (exp_code == 4'h8) ? 2'h2 : 2'h3, 1'b1);
         `CHK({pend, ovr, rsn_o}, {2'b10, exp_rsn})
         `CHK(code, exp_code)
         host.take(rd_v);
         `CHK(rd_v, {10'h001, exp_rsn, exp_code})
         `CHK(pend, 1'b0)
      end
      $display("test all codes done");
      pulse(14'h0001, 1'b0, 2'h0, 1'b1);
      pulse(14'h0400, 1'b0, 2'h0, 1'b1);
      `CHK({pend, ovr, code}, 6'b110010)
      host.wr(link_event_pkg::addr_status, 16'h0080);
      `CHK({pend, ovr}, 2'b11)
      host.wr(link_event_pkg::addr_status, 16'h0040);
      `CHK({pend, ovr}, 2'b00)
      pulse(14'h0002, 1'b1, 2'h0, 1'b1);
      `CHK({pend, ovr, code, rsn_o}, 8'hcd)
      host.take(rd_v);
      `CHK(rd_v, 16'h00d3)
      `CHK({pend, ovr}, 2'b00)
      pulse(14'h0000, 1'b1, 2'h0, 1'b1);
      `CHK({pend, ovr, code, rsn_o}, 8'h8e)
      host.take(rd_v);
      `CHK(rd_v, 16'h0063)
      pulse(14'h0008, 1'b0, 2'h0, 1'b0);
      `CHK({pend, code, rsn_o}, 7'h55)
      host.take(rd_v);
      `CHK(rd_v, 16'h0055)
      $display("test overrun and reasons done");
      ctl(16'h0000);
      pulse(14'h030a, 1'b1, 2'h0, 1'b1);
      `CHK({pend, ovr}, 2'b00)
      $display("test gating done");
      @(posedge mclk);
      clk_en <= 1'b0;
      pulse(14'h0001, 1'b0, 2'h0, 1'b1);
      @(posedge mclk);
      clk_en <= 1'b1;
      `CHK(pend, 1'b0)
      pulse(14'h0001, 1'b0, 2'h0, 1'b1);
      pulse(14'h0001, 1'b0, 2'h0, 1'b1);
      `CHK({pend, ovr, code}, 6'b110010)
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      `CHK({pend, ovr, code, wen, ben, xen}, 9'h000)
      pulse(14'h0800, 1'b0, 2'h0, 1'b1);
      `CHK({pend, ovr, code}, 6'b101101)
      $display("test freeze and reset done");
      print_verdict();
   end
   initial
   begin
      #20000;
      failures++;
      print_verdict();
   end
endmodule
